// ### eeprom_port.sv
// Serial instruction port with 256 x 16 array, enable latch and timed programming
`timescale 1ns/10ps
`include "eeprom_port_regs.svh"
module eeprom_port #(
    parameter int PROG_CYCLES = `TWP_NS / `CLK_PERIOD_NS  // Self-timed program length
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Serial pins from the master
    input  wire logic select_in,
    input  wire logic serial_clock,
    input  wire logic serial_in,
    // Serial output pin, two signals: data and enable
    output logic      serial_out,
    output logic      serial_out_oe
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic sel_s1, sel_s2, sel_s3;   // Select: two stages plus edge history
    logic sk_s1,  sk_s2,  sk_s3;    // Serial clock: two stages plus history
    logic din_s1, din_s2;           // Serial data in

    // Only the second stage and later feed logic, guarding metastability
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            sel_s3 <= 1'b0;
            sk_s1  <= 1'b0;
            sk_s2  <= 1'b0;
            sk_s3  <= 1'b0;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            sel_s1 <= select_in;
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
            sk_s1  <= serial_clock;
            sk_s2  <= sk_s1;
            sk_s3  <= sk_s2;
            din_s1 <= serial_in;
            din_s2 <= din_s1;
        end
    end

    // Edge strobes in the system clock domain
    logic sel_rise;                 // Select went high
    logic sel_fall;                 // Select went low
    logic sk_rise;                  // Serial clock rising edge
    assign sel_rise = sel_s2 & ~sel_s3;
    assign sel_fall = ~sel_s2 & sel_s3;
    assign sk_rise  = sk_s2 & ~sk_s3 & sel_s2; // Clock gated by select

    // ------------------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------------------
    logic [`DATA_BITS-1:0] mem [`WORDS];  // Non-volatile words, never reset
    logic                  mem_we;        // Programming finished this cycle
    logic                  mem_all;       // Job touches every word

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    eeprom_port_pkg::state_t    state_q, state_d;       // Frame machine
    logic [`CNT_BITS-1:0]       cnt_q, cnt_d;           // Bit within field
    logic [`OPC_BITS-1:0]       opc_q, opc_d;           // Opcode shifter
    logic [`ADDR_BITS-1:0]      addr_q, addr_d;         // Address shifter
    logic [`DATA_BITS-1:0]      data_q, data_d;         // Write data shifter
    logic [`DATA_BITS-1:0]      rd_q, rd_d;             // Read-out shifter
    logic                       dout_q, dout_d;         // Read bit on the pin
    logic                       done_q, done_d;         // Full frame received
    eeprom_port_pkg::cmd_t      cmd_q, cmd_d;           // Decoded instruction
    logic                       wen_q, wen_d;           // Write enable latch
    logic                       busy_q, busy_d;         // Programming running
    logic                       stat_q, stat_d;         // Status shown on pin
    logic [`PROG_CNT_BITS-1:0]  pcnt_q, pcnt_d;         // Program timer
    eeprom_port_pkg::prog_job_t job_q, job_d;           // Job being programmed

    // Full address as the last bit arrives
    logic [`ADDR_BITS-1:0] addr_full;
    assign addr_full = {addr_q[`ADDR_BITS-2:0], din_s2};

    // ------------------------------------------------------------------------
    // Instruction decode from opcode and address top bits
    // ------------------------------------------------------------------------
    function automatic eeprom_port_pkg::cmd_t decode(
        input logic [`OPC_BITS-1:0] opc,
        input logic [1:0]           ext
    );
        eeprom_port_pkg::cmd_t c;
        c = eeprom_port_pkg::CMD_READ;
        case (opc)
            `OPC_READ:  c = eeprom_port_pkg::CMD_READ;
            `OPC_WRITE: c = eeprom_port_pkg::CMD_WRITE;
            `OPC_ERASE: c = eeprom_port_pkg::CMD_ERASE;
            default: begin
                // Extended group selected by the address top bits
                case (ext)
                    `EXT_WEN:  c = eeprom_port_pkg::CMD_WRITE_ENABLE;
                    `EXT_WALL: c = eeprom_port_pkg::write_all_cmd;
                    `EXT_EALL: c = eeprom_port_pkg::erase_all_cmd;
                    default:   c = eeprom_port_pkg::write_disable_cmd;
                endcase
            end
        endcase
        return c;
    endfunction : decode

    // ------------------------------------------------------------------------
    // Next-state logic: frame, execution and programming timer
    // ------------------------------------------------------------------------
    eeprom_port_pkg::cmd_t dec_cmd;     // Decode of the frame in flight
    logic                  prog_cmd;    // Frame is a programming instruction

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        opc_d   = opc_q;
        addr_d  = addr_q;
        data_d  = data_q;
        rd_d    = rd_q;
        dout_d  = dout_q;
        done_d  = done_q;
        cmd_d   = cmd_q;
        wen_d   = wen_q;
        busy_d  = busy_q;
        stat_d  = stat_q;
        pcnt_d  = pcnt_q;
        job_d   = job_q;
        mem_we  = 1'b0;
        mem_all = (job_q.cmd == eeprom_port_pkg::write_all_cmd) ||
                  (job_q.cmd == eeprom_port_pkg::erase_all_cmd);
        // Top address bits taken from the full address, as A0 may be arriving now
        dec_cmd = decode(opc_q, addr_full[`ADDR_BITS-1:`ADDR_BITS-2]);
        prog_cmd = (cmd_q == eeprom_port_pkg::CMD_WRITE) ||
                   (cmd_q == eeprom_port_pkg::write_all_cmd) ||
                   (cmd_q == eeprom_port_pkg::CMD_ERASE) ||
                   (cmd_q == eeprom_port_pkg::erase_all_cmd);

        // Self-timed programming runs regardless of select activity
        if (busy_q) begin
            if (pcnt_q == PROG_CYCLES[`PROG_CNT_BITS-1:0] - 1'b1) begin
                busy_d = 1'b0;
                mem_we = 1'b1;
            end else begin
                pcnt_d = pcnt_q + 1'b1;
            end
        end

        if (sel_rise) begin
            // New selection restarts the frame from scratch
            state_d = eeprom_port_pkg::ST_IDLE;
            cnt_d   = '0;
            done_d  = 1'b0;
            dout_d  = 1'b0;
        end else if (sel_fall) begin
            // Frame ends; completed control frames take effect now
            state_d = eeprom_port_pkg::ST_IDLE;
            done_d  = 1'b0;
            if (done_q) begin
                case (cmd_q)
                    eeprom_port_pkg::CMD_WRITE_ENABLE:  wen_d = 1'b1;
                    eeprom_port_pkg::write_disable_cmd: wen_d = 1'b0;
                    default: begin
                        // Programming needs the latch and an idle array
                        if (prog_cmd && wen_q && !busy_q) begin
                            busy_d    = 1'b1;
                            stat_d    = 1'b1;
                            pcnt_d    = '0;
                            job_d.cmd = cmd_q;
                            job_d.addr = addr_q;
                            job_d.data = data_q;
                        end
                    end
                endcase
            end
        end else if (sk_rise) begin
            // One serial bit captured on the serial clock rise
            case (state_q)
                eeprom_port_pkg::ST_IDLE: begin
                    if (din_s2) begin
                        state_d = eeprom_port_pkg::ST_OPC;
                        cnt_d   = '0;
                        // Start bit clears a ready display
                        if (!busy_q) begin
                            stat_d = 1'b0;
                        end
                    end
                end
                eeprom_port_pkg::ST_OPC: begin
                    opc_d = {opc_q[`OPC_BITS-2:0], din_s2};
                    cnt_d = cnt_q + 1'b1;
                    if (cnt_q == `OPC_LAST) begin
                        state_d = eeprom_port_pkg::ST_ADDR;
                        cnt_d   = '0;
                    end
                end
                eeprom_port_pkg::ST_ADDR: begin
                    addr_d = addr_full;
                    cnt_d  = cnt_q + 1'b1;
                    if (cnt_q == `ADDR_LAST) begin
                        cnt_d = '0;
                        cmd_d = dec_cmd;
                        case (dec_cmd)
                            eeprom_port_pkg::CMD_READ: begin
                                // Load word, present dummy zero first
                                state_d = eeprom_port_pkg::ST_RD;
                                rd_d    = mem[addr_full];
                                dout_d  = 1'b0;
                            end
                            eeprom_port_pkg::CMD_WRITE,
                            eeprom_port_pkg::write_all_cmd: begin
                                state_d = eeprom_port_pkg::ST_DATA;
                            end
                            default: begin
                                state_d = eeprom_port_pkg::ST_DONE;
                                done_d  = 1'b1;
                            end
                        endcase
                    end
                end
                eeprom_port_pkg::ST_DATA: begin
                    data_d = {data_q[`DATA_BITS-2:0], din_s2};
                    cnt_d  = cnt_q + 1'b1;
                    if (cnt_q == `DATA_LAST) begin
                        state_d = eeprom_port_pkg::ST_DONE;
                        done_d  = 1'b1;
                        cnt_d   = '0;
                    end
                end
                eeprom_port_pkg::ST_RD: begin
                    // Most significant bit first, zeros after the word
                    dout_d = rd_q[`DATA_BITS-1];
                    rd_d   = {rd_q[`DATA_BITS-2:0], 1'b0};
                end
                eeprom_port_pkg::ST_DONE: begin
                    // Extra clocks after a full frame are ignored
                    state_d = eeprom_port_pkg::ST_DONE;
                end
                default: begin
                    state_d = eeprom_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= eeprom_port_pkg::ST_IDLE;
            cnt_q   <= '0;
            opc_q   <= '0;
            addr_q  <= '0;
            data_q  <= '0;
            rd_q    <= '0;
            dout_q  <= 1'b0;
            done_q  <= 1'b0;
            cmd_q   <= eeprom_port_pkg::CMD_READ;
            wen_q   <= 1'b0;
            busy_q  <= 1'b0;
            stat_q  <= 1'b0;
            pcnt_q  <= '0;
            job_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            opc_q   <= opc_d;
            addr_q  <= addr_d;
            data_q  <= data_d;
            rd_q    <= rd_d;
            dout_q  <= dout_d;
            done_q  <= done_d;
            cmd_q   <= cmd_d;
            wen_q   <= wen_d;
            busy_q  <= busy_d;
            stat_q  <= stat_d;
            pcnt_q  <= pcnt_d;
            job_q   <= job_d;
        end
    end

    // ------------------------------------------------------------------------
    // Array words: one writer per word, committed when the timer expires
    // ------------------------------------------------------------------------
    // No reset: contents must survive reset like non-volatile cells
    for (genvar w = 0; w < `WORDS; w++) begin : g_word
        logic                  hit;    // This word is programmed now
        logic [`DATA_BITS-1:0] value;  // Value programmed into it
        assign hit   = mem_we && (mem_all || (job_q.addr == `ADDR_BITS'(w)));
        assign value = ((job_q.cmd == eeprom_port_pkg::CMD_ERASE) ||
                        (job_q.cmd == eeprom_port_pkg::erase_all_cmd)) ?
                       `ERASED_WORD : job_q.data;
        always_ff @(posedge clock) begin
            if (hit) begin
                mem[w] <= value;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Serial output pin
    // ------------------------------------------------------------------------
    // Driven only while selected: read data, or status without any clock
    assign serial_out_oe = sel_s2 &&
                           ((state_q == eeprom_port_pkg::ST_RD) || stat_q);
    assign serial_out    = stat_q ? ~busy_q : dout_q;

endmodule : eeprom_port

// ### eeprom_port_chk.sv
// Pin-level concurrent checks for the serial instruction port
`timescale 1ns/10ps
module port_chk #(
    parameter int PROG_CYCLES = 50  // Program length handed on from the port
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Serial pins
    input wire logic select_in,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // ------------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------------
    logic        sclk_q, sclk_d;  // Serial clock one cycle ago
    logic        sel_q, sel_d;    // Select one cycle ago
    logic [7:0]  idle_q, idle_d;  // Cycles since a serial clock rise
    logic [20:0] fall_q, fall_d;  // Cycles since a select fall
    // Next values; both counters saturate so a long pause never wraps
    always_comb begin
        sclk_d = serial_clock;
        sel_d  = select_in;
        idle_d = (serial_clock && !sclk_q) ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
        fall_d = (sel_q && !select_in) ? 21'h000000 : fall_q + {20'h00000, fall_q != 21'h1FFFFF};
    end
    // Registers; idle starts high because no edge has been seen
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;
            sel_q  <= 1'b0;
            idle_q <= 8'hFF;
            fall_q <= 21'h000000;
        end else begin
            sclk_q <= sclk_d;
            sel_q  <= sel_d;
            idle_q <= idle_d;
            fall_q <= fall_d;
        end
    end
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    desel_off_a: assert property (!select_in [*4] |-> !serial_out_oe)
        else $error("output driven while deselected");
    sel_drop_a: assert property ($fell(select_in) |-> ##[1:5] !serial_out_oe)
        else $error("output not released after select fall");
    oe_sel_a: assert property ($rose(serial_out_oe) |-> select_in && $past(select_in, 2))
        else $error("output enabled without select");
    fall_clk_a: assert property (serial_out_oe && $past(serial_out_oe) && $fell(serial_out)
        |-> $past(serial_clock) && !$past(serial_clock, 6))
        else $error("output fell without a serial clock rise");
    rise_clk_a: assert property (serial_out_oe && $past(serial_out_oe) && $rose(serial_out)
        |-> ($past(serial_clock) && !$past(serial_clock, 6)) || idle_q > 8'h0C)
        else $error("output rose off the serial clock");
    busy_bound_a: assert property (serial_out_oe && !serial_out && idle_q > 8'h0C
        |-> fall_q < PROG_CYCLES + 8)
        else $error("busy shown past the program time");
    start_clear_a: assert property (serial_out_oe && serial_out && idle_q > 8'h0C && select_in
        && $rose(serial_clock) && serial_in |-> ##[2:6] !serial_out_oe)
        else $error("ready status not cleared by start bit");
    ready_hold_a: assert property (serial_out_oe && serial_out && idle_q > 8'h0C && select_in
        && !$rose(serial_clock) |=> serial_out_oe && serial_out)
        else $error("ready status dropped without clock");
endmodule : port_chk
bind eeprom_port port_chk #(.PROG_CYCLES(PROG_CYCLES)) chk (
    .clock(clock), .sys_rst(sys_rst), .select_in(select_in), .serial_clock(serial_clock),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

// ### eeprom_port_pkg.sv
// Types shared by the serial instruction port
package eeprom_port_pkg;

    // ------------------------------------------------------------------------
    // Decoded instructions
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_READ             = 3'h0,
        CMD_WRITE            = 3'h1,
        CMD_ERASE            = 3'h2,
        CMD_WRITE_ENABLE     = 3'h3,
        write_all_cmd        = 3'h4,
        write_disable_cmd    = 3'h5,
        erase_all_cmd        = 3'h6
    } cmd_t;

    // ------------------------------------------------------------------------
    // Frame states, Gray coded along start, opcode, address, data, done
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_OPC  = 3'h1,
        ST_ADDR = 3'h3,
        ST_DATA = 3'h2,
        ST_DONE = 3'h6,
        ST_RD   = 3'h7
    } state_t;

    // ------------------------------------------------------------------------
    // One programming job: instruction, location, pattern
    // ------------------------------------------------------------------------
    typedef struct packed {
        cmd_t        cmd;
        logic [7:0]  addr;
        logic [15:0] data;
    } prog_job_t;

endpackage : eeprom_port_pkg

// ### eeprom_port_regs.svh
// Constants of the serial instruction port: field sizes, encodings, timing
`ifndef EEPROM_PORT_REGS_SVH
`define EEPROM_PORT_REGS_SVH

// ----------------------------------------------------------------------------
// Frame field sizes
// ----------------------------------------------------------------------------
`define OPC_BITS        2
`define ADDR_BITS       8
`define DATA_BITS       16
`define WORDS           256
`define CNT_BITS        5

// ----------------------------------------------------------------------------
// Last bit index of each field (counter compare values)
// ----------------------------------------------------------------------------
`define OPC_LAST        5'h01
`define ADDR_LAST       5'h07
`define DATA_LAST       5'h0F

// ----------------------------------------------------------------------------
// Opcode and extended (address top bits) encodings
// ----------------------------------------------------------------------------
`define OPC_EXT         2'h0
`define OPC_WRITE       2'h1
`define OPC_READ        2'h2
`define OPC_ERASE       2'h3
`define EXT_WDIS        2'h0
`define EXT_WALL        2'h1
`define EXT_EALL        2'h2
`define EXT_WEN         2'h3

// ----------------------------------------------------------------------------
// Values and timing
// ----------------------------------------------------------------------------
`define ERASED_WORD     16'hFFFF
`define CLK_PERIOD_NS   25
`define TWP_NS          15000000
`define PROG_CNT_BITS   20

`endif

// ### serial_master.sv
// Serial bus master model driving select, clock and data of the port
`timescale 1ns/10ps
module serial_master (
    // Bench clock that paces the link
    input  wire logic clock,
    // Link pins
    output logic      select_in,
    output logic      serial_clock,
    output logic      serial_in,
    input  wire logic serial_pin  // Resolved data line, z when released
);
    // Idle at time zero: deselected, link clock low
    initial begin
        select_in    = 1'b0;
        serial_clock = 1'b0;
        serial_in    = 1'b0;
    end
    // Deselected gap; data churns so a stale level cannot look valid
    task automatic gap();
        select_in = 1'b0;
        repeat (48) begin
            serial_in = ~serial_in;
            @(negedge clock);
        end
    endtask : gap
    // One frame of n bits, MSB first; rd keeps the last 17 pin samples
    task automatic frame(input logic [31:0] bits, input int n, output logic [16:0] rd);
        rd = 17'h00000;
        select_in = 1'b1;
        serial_in = 1'b0;
        repeat (8) @(negedge clock);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = bits[i];
            repeat (4) @(negedge clock);
            rd = {rd[15:0], serial_pin};
            serial_clock = 1'b1;
            repeat (4) @(negedge clock);
            serial_clock = 1'b0;
        end
        gap();
    endtask : frame
    // Status look with no link clock at all
    task automatic poll(output logic s);
        select_in = 1'b1;
        repeat (8) @(negedge clock);
        s = serial_pin;
        gap();
    endtask : poll
endmodule : serial_master

// ### tb.sv
// Self-checking bench for the serial instruction port
`timescale 1ns/10ps
`include "eeprom_port_regs.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb;
    // ------------------------------------------------------------------------
    // Settings and signals
    // ------------------------------------------------------------------------
    localparam int          PROG  = 400;      // Shortened program time
    localparam int          LIMIT = 40000;    // Run ceiling in cycles
    localparam logic [15:0] PAT   = 16'hA5C3; // Write-all pattern
    logic clock;
    logic sys_rst;
    logic select_in;
    logic serial_clock;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    wire  serial_pin;         // Data line as the master sees it
    int   miscompares;
    int   tests_run;
    int   cycles;
    // No pull on the data line: released means z
    assign serial_pin = serial_out_oe ? serial_out : 1'bz;
    eeprom_port #(.PROG_CYCLES(PROG)) dut (.clock(clock), .sys_rst(sys_rst),
        .select_in(select_in), .serial_clock(serial_clock), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe(serial_out_oe));
    serial_master master (.clock(clock), .select_in(select_in),
        .serial_clock(serial_clock), .serial_in(serial_in), .serial_pin(serial_pin));
    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up
    // A hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end
    function automatic logic [31:0] ext(input logic [1:0] e);
        return {21'h000000, 1'b1, `OPC_EXT, e, 6'h00};
    endfunction : ext
    function automatic logic [31:0] wr(input logic [1:0] op, logic [7:0] a, logic [15:0] d);
        return {5'h00, 1'b1, op, a, d};
    endfunction : wr
    task automatic cmd(input logic [31:0] b, input int n);
        logic [16:0] r;
        master.frame(b, n, r);
    endtask : cmd
    // Read with optional leading zeros; dummy zero then the word
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input int lead);
        logic [16:0] r;
        master.frame({4'h0, 1'b1, `OPC_READ, a, 17'h00000}, 28 + lead, r);
        `CHK("read word", {1'b0, e}, r)
    endtask : rd_chk
    task automatic poll_chk(input logic e);
        logic s;
        master.poll(s);
        `CHK("status pin", e, s)
    endtask : poll_chk
    // Programming frame: busy soon after, ready once the time is up
    task automatic prog_chk(input logic [31:0] b, input int n);
        cmd(b, n);
        poll_chk(1'b0);
        repeat (PROG) @(negedge clock);
        poll_chk(1'b1);
    endtask : prog_chk
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_power_up();
        poll_chk(1'bz);
        cmd(wr(`OPC_EXT, {`EXT_WALL, 6'h00}, 16'h0000), 27);
        poll_chk(1'bz);
    endtask : t_power_up
    task automatic t_fill();
        cmd(ext(`EXT_WEN), 11);
        prog_chk(wr(`OPC_EXT, {`EXT_WALL, 6'h00}, PAT), 27);
        poll_chk(1'b1);
        rd_chk(8'h00, PAT, 0);
        rd_chk(8'hFF, PAT, 3);
    endtask : t_fill
    task automatic t_guard();
        cmd(ext(`EXT_WDIS), 11);
        cmd(wr(`OPC_WRITE, 8'h5A, 16'h1234), 27);
        poll_chk(1'bz);
        rd_chk(8'h5A, PAT, 0);
    endtask : t_guard
    task automatic t_write();
        cmd(ext(`EXT_WEN), 11);
        prog_chk(wr(`OPC_WRITE, 8'h5A, 16'h1234), 27);
        rd_chk(8'h5A, 16'h1234, 0);
        rd_chk(8'h5B, PAT, 0);
        cmd(wr(`OPC_WRITE, 8'h5B, 16'h0000) >> 8, 19);
        poll_chk(1'bz);
        rd_chk(8'h5B, PAT, 0);
    endtask : t_write
    task automatic t_erase();
        prog_chk({21'h000000, 1'b1, `OPC_ERASE, 8'h5B}, 11);
        rd_chk(8'h5B, 16'hFFFF, 0);
        prog_chk(ext(`EXT_EALL), 11);
        rd_chk(8'h5A, 16'hFFFF, 0);
        cmd(ext(`EXT_WDIS), 11);
    endtask : t_erase
    // Main sequence
    initial begin
        sys_rst     = 1'b1;
        miscompares = 0;
        tests_run   = 0;
        cycles      = 0;
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        repeat (4) @(negedge clock);
        t_power_up();
        t_fill();
        t_guard();
        t_write();
        t_erase();
        wrap_up();
    end
endmodule : tb
